// ---- common/sensor_config_stats_consts.svh ----
`ifndef SENSOR_CONFIG_STATS_CONSTS_SVH
`define SENSOR_CONFIG_STATS_CONSTS_SVH

`define ADDR_PIXEL_TOTAL 8'h06
`define ADDR_PEAK_PIXEL 8'h07
`define ADDR_RSVD_A 8'h08
`define ADDR_RSVD_B 8'h09
`define ADDR_SENSOR_SETUP 8'h0A
`define ADDR_ADVANCED_SETUP 8'h0B
`define ADDR_RESULT_LOW 8'h0C
`define ADDR_RESULT_HIGH 8'h0D

`define SETUP_RESET 8'h09
`define SETUP_WR_MASK 8'h7F
`define SETUP_GATING_BIT 6
`define SETUP_TEST_BIT 5
`define SETUP_CPI_BIT 4
`define ADV_BUSY_BIT 7
`define ADV_PULLUP_BIT 2
`define ADV_EXPOSURE_BIT 1
`define ADV_PACE_BIT 0
`define ADV_RESET 3'h0

`define PIXEL_TOTAL_CEIL 8'hDD
`define CLK_FREQ_KHZ 125000
`define SELFTEST_TIME_MS 200
`define SELFTEST_CYCLES (`SELFTEST_TIME_MS * `CLK_FREQ_KHZ)
`define SELFTEST_CNT_W 25

`endif

// ---- common/sensor_config_stats_pkg.sv ----
package sensor_config_stats_pkg;

  typedef enum logic {
    TEST_IDLE,
    TEST_RUN
  } test_state_e;

  typedef struct packed {
    logic [7:0] total;
    logic [5:0] peak;
  } frame_stats_s;

  typedef struct packed {
    logic port_pullup_off;
    logic exposure_auto_off;
    logic constant_frame_pace;
  } advanced_bits_s;

endpackage : sensor_config_stats_pkg

// ---- src/sensor_config_stats_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sensor_config_stats_consts.svh"

module sensor_config_stats_regs #(
  parameter int unsigned SELFTEST_CYCLES = `SELFTEST_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic PIX_VALID,
  input wire logic [5:0] PIX_VALUE,
  input wire logic FRAME_DONE,
  input wire logic ILLUM_NEEDED,
  input wire logic [15:0] TEST_CRC,
  input wire logic BOUNDS_BUSY,
  output logic LED_ON,
  output logic SELFTEST_RUN,
  output logic COUNTS_PER_INCH_SELECT,
  output logic MOTION_CPI_BIT,
  output logic PORT_PULLUP_OFF,
  output logic EXPOSURE_AUTO_OFF,
  output logic CONSTANT_FRAME_PACE
);

  // ------------------------------------------------------------
  // Address decoding.
  // ------------------------------------------------------------

  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    hit = (addr == target);
  endfunction : hit

  logic [7:0] sensor_setup;
  sensor_config_stats_pkg::advanced_bits_s adv;
  sensor_config_stats_pkg::frame_stats_s stats;
  sensor_config_stats_pkg::test_state_e test_state;
  logic [15:0] test_result;
  logic [15:0] pix_acc;
  logic [5:0] pix_peak;
  logic [`SELFTEST_CNT_W-1:0] test_count;
  logic led;
  logic [7:0] rdata;

  wire logic testing = (test_state == sensor_config_stats_pkg::TEST_RUN);
  wire logic wr_setup = REG_WR && !testing &&
                        hit(REG_ADDR, `ADDR_SENSOR_SETUP);
  wire logic wr_adv = REG_WR && !testing &&
                      hit(REG_ADDR, `ADDR_ADVANCED_SETUP);
  wire logic start_test = wr_setup && REG_WDATA[`SETUP_TEST_BIT];
  wire logic test_last = testing &&
    (test_count == `SELFTEST_CNT_W'(SELFTEST_CYCLES - 1));

  // ------------------------------------------------------------
  // Frame statistics.
  // ------------------------------------------------------------

  wire logic [5:0] pix_in = PIX_VALID ? PIX_VALUE : 6'h00;
  wire logic [15:0] next_acc = pix_acc + {10'h000, pix_in};
  wire logic [5:0] next_peak = (pix_in > pix_peak) ? pix_in : pix_peak;
  wire logic [7:0] acc_high = next_acc[15:8];
  wire logic [7:0] next_total = (acc_high > `PIXEL_TOTAL_CEIL) ?
                                `PIXEL_TOTAL_CEIL : acc_high;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || FRAME_DONE) begin
      pix_acc <= 16'h0000;
      pix_peak <= 6'h00;
    end else begin
      pix_acc <= next_acc;
      pix_peak <= next_peak;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stats <= '0;
    end else if (FRAME_DONE) begin
      stats.total <= next_total;
      stats.peak <= next_peak;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers.
  // ------------------------------------------------------------

  wire logic [7:0] next_setup = REG_WDATA & `SETUP_WR_MASK;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || test_last) begin
      sensor_setup <= `SETUP_RESET;
    end else if (wr_setup) begin
      sensor_setup <= next_setup;
    end
  end

  wire sensor_config_stats_pkg::advanced_bits_s next_adv = '{
    port_pullup_off: REG_WDATA[`ADV_PULLUP_BIT],
    exposure_auto_off: REG_WDATA[`ADV_EXPOSURE_BIT],
    constant_frame_pace: REG_WDATA[`ADV_PACE_BIT]
  };

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || test_last) begin
      adv <= `ADV_RESET;
    end else if (wr_adv) begin
      adv <= next_adv;
    end
  end

  // ------------------------------------------------------------
  // Self-test sequencing.
  // ------------------------------------------------------------

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      test_state <= sensor_config_stats_pkg::TEST_IDLE;
      test_count <= '0;
    end else begin
      case (test_state)
        sensor_config_stats_pkg::TEST_IDLE: begin
          test_count <= '0;
          if (start_test) begin
            test_state <= sensor_config_stats_pkg::TEST_RUN;
          end
        end
        sensor_config_stats_pkg::TEST_RUN: begin
          test_count <= test_count + 1'b1;
          if (test_last) begin
            test_state <= sensor_config_stats_pkg::TEST_IDLE;
          end
        end
        default: begin
          test_state <= sensor_config_stats_pkg::TEST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      test_result <= 16'h0000;
    end else if (test_last) begin
      test_result <= TEST_CRC;
    end
  end

  // ------------------------------------------------------------
  // Light source drive.
  // ------------------------------------------------------------

  wire logic gating = sensor_setup[`SETUP_GATING_BIT];
  wire logic next_led = gating ? ILLUM_NEEDED : 1'b1;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      led <= 1'b1;
    end else begin
      led <= next_led;
    end
  end

  // ------------------------------------------------------------
  // Read path.
  // ------------------------------------------------------------

  wire logic [7:0] adv_view = {BOUNDS_BUSY, 4'h0,
                               adv.port_pullup_off,
                               adv.exposure_auto_off,
                               adv.constant_frame_pace};
  wire logic [7:0] setup_view = {sensor_setup[7:6], testing,
                                 sensor_setup[4:0]};
  logic [7:0] next_rdata;

  always_comb begin
    if (hit(REG_ADDR, `ADDR_PIXEL_TOTAL)) begin
      next_rdata = stats.total;
    end else if (hit(REG_ADDR, `ADDR_PEAK_PIXEL)) begin
      next_rdata = {2'h0, stats.peak};
    end else if (hit(REG_ADDR, `ADDR_SENSOR_SETUP)) begin
      next_rdata = setup_view;
    end else if (hit(REG_ADDR, `ADDR_ADVANCED_SETUP)) begin
      next_rdata = adv_view;
    end else if (hit(REG_ADDR, `ADDR_RESULT_LOW)) begin
      next_rdata = test_result[7:0];
    end else if (hit(REG_ADDR, `ADDR_RESULT_HIGH)) begin
      next_rdata = test_result[15:8];
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdata <= 8'h00;
    end else if (REG_RD) begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Outputs.
  // ------------------------------------------------------------

  assign REG_RDATA = rdata;
  assign LED_ON = led;
  assign SELFTEST_RUN = testing;
  assign COUNTS_PER_INCH_SELECT = sensor_setup[`SETUP_CPI_BIT];
  assign MOTION_CPI_BIT = sensor_setup[`SETUP_CPI_BIT];
  assign PORT_PULLUP_OFF = adv.port_pullup_off;
  assign EXPOSURE_AUTO_OFF = adv.exposure_auto_off;
  assign CONSTANT_FRAME_PACE = adv.constant_frame_pace;

endmodule : sensor_config_stats_regs

`default_nettype wire

// ---- testbench/sensor_config_stats_regs_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checks.
// ----------------------------------------
module sensor_config_stats_regs_asserts #(
  parameter int unsigned SELFTEST_CYCLES = 20
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic ILLUM_NEEDED,
  input wire logic BOUNDS_BUSY,
  input wire logic LED_ON,
  input wire logic SELFTEST_RUN,
  input wire logic COUNTS_PER_INCH_SELECT,
  input wire logic MOTION_CPI_BIT,
  input wire logic PORT_PULLUP_OFF,
  input wire logic EXPOSURE_AUTO_OFF,
  input wire logic CONSTANT_FRAME_PACE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  int unsigned run_len;
  wire logic wr_ok = REG_WR && !SELFTEST_RUN;
  wire logic [2:0] adv = {PORT_PULLUP_OFF, EXPOSURE_AUTO_OFF,
    CONSTANT_FRAME_PACE};
  always_ff @(posedge REF_CLK) begin
    run_len <= (SYS_RST || !SELFTEST_RUN) ? 0 : run_len + 1;
  end
  cpi_mirror_a: assert property (
    MOTION_CPI_BIT == COUNTS_PER_INCH_SELECT) else $error("cpi mirror");
  led_gate_a: assert property (
    !LED_ON |-> !$past(ILLUM_NEEDED)) else $error("led off");
  adv_write_a: assert property (
    wr_ok && REG_ADDR == 8'h0B |=> adv == $past(REG_WDATA[2:0]))
    else $error("adv write");
  adv_read_a: assert property (
    REG_RD && REG_ADDR == 8'h0B |=>
    REG_RDATA == {$past(BOUNDS_BUSY), 4'h0, $past(adv)}) else $error("adv rd");
  peak_top_a: assert property (
    REG_RD && REG_ADDR == 8'h07 |=> REG_RDATA[7:6] == 2'h0)
    else $error("peak top");
  total_ceil_a: assert property (
    REG_RD && REG_ADDR == 8'h06 |=> REG_RDATA <= 8'hDD) else $error("ceil");
  test_start_a: assert property (
    wr_ok && REG_ADDR == 8'h0A && REG_WDATA[5] |=> SELFTEST_RUN)
    else $error("test start");
  test_len_a: assert property (
    $fell(SELFTEST_RUN) |-> run_len == SELFTEST_CYCLES) else $error("len");
  test_end_a: assert property (
    $fell(SELFTEST_RUN) |-> !COUNTS_PER_INCH_SELECT && adv == 3'h0)
    else $error("test end");
  cover property ($fell(SELFTEST_RUN));
  cover property (REG_RD && REG_ADDR == 8'h06);
  cover property (!LED_ON);
endmodule : sensor_config_stats_regs_asserts
bind sensor_config_stats_regs sensor_config_stats_regs_asserts #(
  .SELFTEST_CYCLES(SELFTEST_CYCLES)) sensor_config_stats_regs_asserts_inst (.*);
`default_nettype wire

// ---- testbench/host_port_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Controller side of the register port.
// ----------------------------------------
module host_port_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = (a == 8'h0A) ? (d & 8'h7F) : d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~wdata;
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : get
endmodule : host_port_model
`default_nettype wire

// ---- testbench/sensor_config_stats_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Register bank bench.
// ----------------------------------------
module sensor_config_stats_regs_tb;
  localparam int unsigned N = 20;
  logic clk = 1'b0, rst = 1'b1, pv = 1'b0, fd = 1'b0, illum = 1'b0;
  logic busy = 1'b0, wr, rd, led, run, cpi, mcpi, pu, ae, cfp;
  logic [5:0] pix = 6'h00;
  logic [15:0] crc = 16'h0000;
  logic [7:0] addr, wdata, rdata, rv;
  logic [31:0] seed = 32'h40;
  int err_count = 0, num_checks = 0;
  sensor_config_stats_regs #(.SELFTEST_CYCLES(N)) sensor_config_stats_regs_inst (
    .REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .PIX_VALID(pv),
    .PIX_VALUE(pix), .FRAME_DONE(fd), .ILLUM_NEEDED(illum), .TEST_CRC(crc),
    .BOUNDS_BUSY(busy), .LED_ON(led), .SELFTEST_RUN(run),
    .COUNTS_PER_INCH_SELECT(cpi), .MOTION_CPI_BIT(mcpi),
    .PORT_PULLUP_OFF(pu), .EXPOSURE_AUTO_OFF(ae), .CONSTANT_FRAME_PACE(cfp));
  host_port_model host_port_model_inst (.clk(clk), .rdata(rdata),
    .addr(addr), .wr(wr), .wdata(wdata), .rd(rd));
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host_port_model_inst.get(a, rv);
    chk(rv, e);
  endtask : rc
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic frame(input logic full);
    int sum;
    int mx;
    int q[$];
    sum = 0;
    mx = 0;
    for (int i = 0; i < 900; i++) begin
      seed = xs(seed);
      q.push_back(full ? 63 : int'(seed[5:0]));
    end
    foreach (q[i]) begin
      @(negedge clk);
      pv = 1'b1;
      pix = 6'(q[i]);
      fd = (i == 899);
      illum = seed[i % 32];
      sum += q[i];
      mx = (q[i] > mx) ? q[i] : mx;
    end
    @(negedge clk);
    pv = 1'b0;
    fd = 1'b0;
    rc(8'h06, (sum >> 8) > 221 ? 8'hDD : 8'(sum >> 8));
    rc(8'h07, 8'(mx));
  endtask : frame
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    int n = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rc(8'h0A, 8'h09);
    rc(8'h0B, 8'h00);
    rc(8'h20, 8'h00);
    $display("Test reset done");
    frame(1'b0);
    frame(1'b1);
    host_port_model_inst.put(8'h06, 8'h55);
    rc(8'h06, 8'hDD);
    $display("Test frames done");
    busy = 1'b1;
    host_port_model_inst.put(8'h0B, 8'hFF);
    rc(8'h0B, 8'h87);
    host_port_model_inst.put(8'h0A, 8'h50);
    rc(8'h0A, 8'h50);
    chk({6'h00, cpi, mcpi}, 8'h03);
    chk({5'h00, pu, ae, cfp}, 8'h07);
    illum = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, led}, 8'h00);
    illum = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, led}, 8'h01);
    $display("Test config done");
    illum = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rc(8'h0A, 8'h09);
    rc(8'h0B, 8'h80);
    chk({7'h00, led}, 8'h01);
    host_port_model_inst.put(8'h0B, 8'h07);
    crc = seed[15:0];
    host_port_model_inst.put(8'h0A, 8'h30);
    chk({7'h00, run}, 8'h01);
    while (run && n < N + 5) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, run}, 8'h00);
    chk(8'(n), 8'(N));
    rc(8'h0C, crc[7:0]);
    rc(8'h0D, crc[15:8]);
    rc(8'h0A, 8'h09);
    rc(8'h0B, 8'h80);
    host_port_model_inst.put(8'h0A, 8'h50);
    rc(8'h0A, 8'h50);
    $display("Test selftest done");
    end_of_test();
  end
endmodule : sensor_config_stats_regs_tb
`default_nettype wire
